/* File: testbench/cpx_copro_model.sv */
`timescale 1ns/10ps

module cpx_copro_model
(
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        instr_start,
    input  wire        cir_rd,
    input  wire        cir_wr,
    input  wire [15:0] prim,
    input  wire [3:0]  busy_reads,
    input  wire        slow,
    input  wire        berr_en,
    output reg         cir_done,
    output reg         cir_berr,
    output reg  [15:0] cir_rdata
);
    reg [1:0] wait_cnt;
    reg [3:0] served;

    always @(posedge aclk)
    begin
        cir_done <= 1'b0;
        cir_berr <= 1'b0;
        // Toggle so stale data does not hold steady between reads
        cir_rdata <= ~cir_rdata;
        if (!aresetn)
            cir_rdata <= 16'h0000;
        if (!aresetn || instr_start)
        begin
            wait_cnt <= 2'h0;
            served <= 4'h0;
        end
        else if ((cir_rd || cir_wr) && !cir_done && !cir_berr)
        begin
            wait_cnt <= wait_cnt + 2'h1;
            if (wait_cnt == {slow, slow})
            begin
                wait_cnt <= 2'h0;
                cir_berr <= berr_en;
                cir_done <= !berr_en;
                if (cir_rd)
                begin
                    served <= served + 4'h1;
                    cir_rdata <= (served < busy_reads) ? 16'h0200 : prim;
                end
            end
        end
    end
endmodule

/* File: testbench/cpx_exc_monitor.sv */
`timescale 1ns/10ps

module cpx_exc_monitor
(
    input wire        aclk,
    input wire        aresetn,
    input wire        instr_start,
    input wire [15:0] opcode,
    input wire        op_valid,
    input wire        supervisor,
    input wire        cir_rd,
    input wire        cir_wr,
    input wire [15:0] cir_wdata,
    input wire        cir_done,
    input wire        exc_req,
    input wire [7:0]  exc_vector,
    input wire [1:0]  exc_frame,
    input wire        exc_scan_next,
    input wire        exc_ack
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_abort_mask: assert property (
        cir_wr |-> cir_wdata == 16'h4000) else $error("bad abort mask");
    chk_vector_pairs: assert property (
        exc_req |-> (exc_vector == 8'h0D && exc_frame == 2'h3)
        || ((exc_vector == 8'h0B || exc_vector == 8'h08) && exc_frame == 2'h1)
        || ((exc_vector == 8'h07 || exc_vector == 8'h09) && exc_frame == 2'h2))
        else $error("vector/frame mismatch");
    chk_req_hold: assert property (
        exc_req && !exc_ack |=> exc_req && $stable(exc_vector) && $stable(exc_frame))
        else $error("request changed before ack");
    chk_type_fline: assert property (
        instr_start && opcode[8:7] == 2'b11 |=> (!cir_rd && !cir_wr) [*2]
        ##[0:1] (exc_req && exc_vector == 8'h0B)) else $error("illegal type not line-F");
    chk_bad_opword: assert property (
        instr_start && !op_valid && !opcode[8] |=> (!cir_rd && !cir_wr) [*2]
        ##[0:1] (exc_req && exc_vector == 8'h0B)) else $error("bad opword not line-F");
    chk_user_save: assert property (
        instr_start && op_valid && !supervisor && opcode[8:7] == 2'b10 |=> !cir_rd [*2]
        ##[0:1] (exc_req && exc_vector == 8'h08)) else $error("user save not privileged");
    chk_proto_silent: assert property (
        $rose(exc_req) && exc_vector == 8'h0D |-> !$past(cir_wr) && !$past(cir_wr, 2))
        else $error("violation wrote control");
    chk_abort_order: assert property (
        cir_wr && cir_done |=> !cir_wr ##[1:2] exc_req) else $error("no exception after abort");
    chk_trap_scan: assert property (
        exc_req && exc_vector == 8'h07 |-> exc_scan_next) else $error("trap lacks next address");
endmodule

////////////////////////////////////////////////////////////
bind cpx_exc_unit cpx_exc_monitor u_mon (.*);

/* File: testbench/cpx_exc_unit_bench.sv */
`timescale 1ns/10ps

module cpx_exc_unit_bench;
    logic        aclk, aresetn, instr_start, op_valid, supervisor, ea_ctrl_alt, trap_return;
    logic        exc_ack, slow, berr_en, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, wr_seen, got_exc, got_scan;
    logic [15:0] opcode, prim;
    logic [3:0]  busy_reads, s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, rd_data;
    logic [7:0]  got_vec;
    logic [1:0]  got_frm, rd_resp;
    wire         cir_rd, cir_wr, cir_done, cir_berr, irq_service, exc_req, exc_scan_next;
    wire         instr_done, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire         s_axi_rvalid;
    wire  [15:0] cir_wdata, cir_rdata;
    wire  [7:0]  exc_vector;
    wire  [1:0]  exc_frame, s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    int          error_cnt, comparisons, reads, exc_cnt;
    logic [15:0] bad_prim [2] = '{16'h0000, 16'h3F00};

    cpx_exc_unit DUT (.*, .flow_change(1'b0), .irq_pending(1'b0), .s_axi_wstrb(4'hF));
    cpx_copro_model PARTNER (.*);

    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task final_report;
        $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task axi_wr(input logic [3:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
    endtask

    task axi_rd(input logic [3:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        rd_data = s_axi_rdata;
        rd_resp = s_axi_rresp;
    endtask

    // One instruction or return
    task run(input logic ret, input logic [15:0] op, input logic sup,
                       input logic ok, input logic [15:0] pr, input logic [3:0] busy);
        opcode <= op;
        supervisor <= sup;
        op_valid <= ok;
        prim <= pr;
        busy_reads <= busy;
        trap_return <= ret;
        instr_start <= !ret;
        reads = 0;
        wr_seen = 1'b0;
        @(posedge aclk);
        instr_start <= 1'b0;
        trap_return <= 1'b0;
        while (!exc_req && !instr_done)
        begin
            @(posedge aclk);
            if (cir_rd && cir_done)
                reads++;
            wr_seen |= cir_wr;
        end
        got_exc = exc_req;
        got_vec = exc_vector;
        got_frm = exc_frame;
        got_scan = exc_scan_next;
        exc_cnt += got_exc;
        exc_ack <= exc_req;
        @(posedge aclk);
        exc_ack <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask

    task chk_exc(input logic [7:0] v, input logic [1:0] f);
        cmp("taken", 32'h1, got_exc);
        cmp("vector", v, got_vec);
        cmp("frame", f, got_frm);
    endtask

    ////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        final_report;
    end

    initial
    begin
        {aresetn, instr_start, op_valid, supervisor, trap_return, exc_ack, slow, berr_en} = 8'h00;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, opcode, prim, busy_reads} = 39'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
        {ea_ctrl_alt, s_axi_bready, s_axi_rready} = 3'h7;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_rd(4'h0);
        cmp("ctrl reset", 32'h0, rd_data);
        axi_rd(4'hC);
        cmp("bad resp", 32'h2, rd_resp);
        cmp("bad data", 32'h0, rd_data);
        for (int i = 4; i < 8; i++)
        begin
            run(1'b0, {7'h78, i[2:0], 6'h00}, 1'b0, 1'b1, 16'h0000, 4'h0);
            chk_exc(i < 6 ? 8'h08 : 8'h0B, 2'h1);
            cmp("reads", 32'h0, reads);
        end
        run(1'b0, 16'hF000, 1'b1, 1'b0, 16'h0000, 4'h0);
        chk_exc(8'h0B, 2'h1);
        cmp("abort", 32'h0, wr_seen);
        berr_en <= 1'b1;
        run(1'b0, 16'hF000, 1'b1, 1'b1, 16'h0000, 4'h0);
        chk_exc(8'h0B, 2'h1);
        berr_en <= 1'b0;
        slow <= 1'b1;
        for (int i = 0; i < 2; i++)
        begin
            run(1'b0, 16'hF000, 1'b1, 1'b1, bad_prim[i], 4'h0);
            chk_exc(8'h0D, 2'h3);
            cmp("abort", 32'h0, wr_seen);
            run(1'b1, 16'hF000, 1'b1, 1'b1, bad_prim[i], 4'h0);
            cmp("reread", 32'h1, reads);
        end
        run(1'b0, 16'hF000, 1'b0, 1'b1, 16'h8400, 4'h0);
        chk_exc(8'h08, 2'h1);
        cmp("abort", 32'h1, wr_seen);
        ea_ctrl_alt <= 1'b0;
        run(1'b0, 16'hF000, 1'b1, 1'b1, 16'h8A00, 4'h0);
        chk_exc(8'h0B, 2'h1);
        cmp("abort", 32'h1, wr_seen);
        ea_ctrl_alt <= 1'b1;
        run(1'b0, 16'hF040, 1'b1, 1'b1, 16'h0201, 4'h0);
        chk_exc(8'h07, 2'h2);
        cmp("scan next", 32'h1, got_scan);
        for (int m = 0; m < 2; m++)
        begin
            axi_wr(4'h0, m);
            run(1'b0, 16'hF000, 1'b1, 1'b1, 16'h0300, 4'h0);
            cmp("no trace", 32'h0, got_exc);
            cmp("reads", 32'h1, reads);
        end
        run(1'b0, 16'hF000, 1'b1, 1'b1, 16'h2300, 4'h0);
        chk_exc(8'h09, 2'h2);
        axi_wr(4'h0, 32'h2);
        axi_rd(4'h0);
        cmp("ctrl", 32'h2, rd_data[1:0]);
        run(1'b0, 16'hF000, 1'b1, 1'b1, 16'h4200, 4'h2);
        chk_exc(8'h09, 2'h2);
        cmp("poll reads", 32'h3, reads);
        run(1'b0, 16'hF040, 1'b1, 1'b1, 16'h0200, 4'h0);
        cmp("cond reads", 32'h1, reads);
        chk_exc(8'h09, 2'h2);
        axi_rd(4'h8);
        cmp("last vec", 32'h09, rd_data[15:8]);
        cmp("exc count", exc_cnt[7:0], rd_data[23:16]);
        final_report;
    end
endmodule

/* File: verilog/cpx_defines.vh */
`ifndef CPX_DEFINES_VH
`define CPX_DEFINES_VH

// Vector numbers
`define CPX_VEC_PROTOCOL    8'h0D
`define CPX_VEC_FLINE       8'h0B
`define CPX_VEC_PRIVILEGE   8'h08
`define CPX_VEC_TRAP        8'h07
`define CPX_VEC_TRACE       8'h09

// Frame formats
`define CPX_FRM_NONE        2'h0
`define CPX_FRM_PRE4        2'h1
`define CPX_FRM_POST6       2'h2
`define CPX_FRM_MID10       2'h3

// Primitive word fields
`define CPX_PRIM_CA         15
`define CPX_PRIM_PF         14
`define CPX_PRIM_DR         13
`define CPX_PRIM_IA         14
`define CPX_PRIM_FN_HI      13
`define CPX_PRIM_FN_LO      8
`define CPX_PRIM_SUPCHK     6'h04
`define CPX_PRIM_TRUE_BIT   0

// Opcode fields
`define CPX_OP_TYPE_HI      8
`define CPX_OP_TYPE_LO      6

// Type codes, opcode bits 8-6
`define CPX_TYPE_GEN        3'h0
`define CPX_TYPE_COND       3'h1
`define CPX_TYPE_TRAPCC     3'h1
`define CPX_TYPE_SAVE       3'h4
`define CPX_TYPE_RESTORE    3'h5

// Trace mode values
`define CPX_TRACE_OFF       2'h0
`define CPX_TRACE_FLOW      2'h1
`define CPX_TRACE_ALL       2'h2

// Abort mask
`define CPX_ABORT_MASK      16'h4000

// AXI-lite map
`define CPX_ADDR_CTRL       4'h0
`define CPX_ADDR_STATUS     4'h4
`define CPX_ADDR_RESULT     4'h8
`define CPX_CTRL_RESET      2'h0

`endif

/* File: verilog/cpx_exc_unit.v */
// Behaviour
// RQ1 - Protocol violation sends no control register write
// RQ2 - Protocol violation: midinstruction frame, vector 13
// RQ3 - After return, reread response register
// RQ4 - Type 110/111 opcodes: line-F, no communication
// RQ5 - Undecodable type 000-101 opcodes: line-F
// RQ6 - Opcode-only line-F skips control write
// RQ7 - EA-incompatible primitive: abort, then line-F
// RQ8 - Bus error on first access: line-F
// RQ9 - Line-F: four-word frame, vector 11
// RQ10 - User save/restore: privilege violation first
// RQ11 - User supervisor check: abort, privilege violation
// RQ12 - Privilege violation: four-word frame, vector 8
// RQ13 - Trap true null: six-word frame, vector 7
// RQ14 - Trace every instruction or flow changes
// RQ15 - Trace leaves save/restore/conditional protocol unchanged
// RQ16 - No trace: stop after come-again zero
// RQ17 - Trace pending: poll until finished null; code polls only in trace-all mode, flow trace is taken at come-again zero
// RQ18 - Coprocessor returns unfinished null while busy
// RQ19 - Polling may service interrupts when allowed
// RQ20 - Flow trace needs status primitive, direction set
// RQ21 - Some come-again zero primitives illegal conditionally
// RQ22 - Invalid primitive encoding is protocol violation
// RQ23 - Function bits all zero/one are invalid
// RQ24 - Vector and frame together, abort first
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/10ps
`include "cpx_defines.vh"

module cpx_exc_unit
(
    input  wire        aclk,
    input  wire        aresetn,
    // Instruction start
    input  wire        instr_start,
    input  wire [15:0] opcode,
    input  wire        op_valid,
    input  wire        supervisor,
    input  wire        ea_ctrl_alt,
    input  wire        flow_change,
    input  wire        trap_return,
    // Coprocessor interface register port
    output reg         cir_rd,
    output reg         cir_wr,
    output reg  [15:0] cir_wdata,
    input  wire        cir_done,
    input  wire        cir_berr,
    input  wire [15:0] cir_rdata,
    // Interrupt handshake
    input  wire        irq_pending,
    output reg         irq_service,
    // Stacking sequencer
    output reg         exc_req,
    output reg  [7:0]  exc_vector,
    output reg  [1:0]  exc_frame,
    output reg         exc_scan_next,
    input  wire        exc_ack,
    output reg         instr_done,
    // AXI4-Lite
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);

    localparam ST_IDLE  = 3'h0;
    localparam ST_READ  = 3'h1;
    localparam ST_EVAL  = 3'h2;
    localparam ST_ABORT = 3'h3;
    localparam ST_EXC   = 3'h4;
    localparam ST_IRQ   = 3'h5;

    reg [2:0]  state;
    reg [1:0]  trace_mode_bits;
    reg [15:0] prim;
    reg        trace_pend;
    reg        first_acc;
    reg [7:0]  pend_vec;
    reg [1:0]  pend_frm;
    reg        pend_scan;
    reg [7:0]  last_vec;
    reg        exc_count_en;
    reg [7:0]  exc_count;

    wire [2:0] op_type = opcode[`CPX_OP_TYPE_HI:`CPX_OP_TYPE_LO];
    wire       cat_cond = (op_type == `CPX_TYPE_COND) || (op_type == 3'h2)
                          || (op_type == 3'h3);
    wire       cat_gen  = (op_type == `CPX_TYPE_GEN);
    wire       cat_sr   = (op_type == `CPX_TYPE_SAVE) || (op_type == `CPX_TYPE_RESTORE);
    wire       come_again_bit          = prim[`CPX_PRIM_CA];
    wire       processing_finished_bit = prim[`CPX_PRIM_PF];
    wire       interrupts_allowed_bit  = prim[`CPX_PRIM_IA];
    wire       direction_bit           = prim[`CPX_PRIM_DR];

    wire p_invalid;
    wire p_null;
    wire p_supchk;
    wire p_status;
    wire p_ea;
    wire flow_hit = cat_gen && p_status && direction_bit
                    && (trace_mode_bits == `CPX_TRACE_FLOW);

    cpx_prim_decode u_dec
    (
        .prim      (prim),
        .cond_cat  (cat_cond),
        .invalid   (p_invalid),
        .is_null   (p_null),
        .is_supchk (p_supchk),
        .is_status (p_status),
        .ea_op     (p_ea)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Exception selection and primitive sequencing

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state         <= ST_IDLE;
            prim          <= 16'h0000;
            trace_pend    <= 1'b0;
            first_acc     <= 1'b0;
            pend_vec      <= 8'h00;
            pend_frm      <= `CPX_FRM_NONE;
            pend_scan     <= 1'b0;
            cir_rd        <= 1'b0;
            cir_wr        <= 1'b0;
            cir_wdata     <= 16'h0000;
            irq_service   <= 1'b0;
            exc_req       <= 1'b0;
            exc_vector    <= 8'h00;
            exc_frame     <= `CPX_FRM_NONE;
            exc_scan_next <= 1'b0;
            instr_done    <= 1'b0;
            last_vec      <= 8'h00;
            exc_count_en  <= 1'b0;
        end
        else
        begin
            instr_done   <= 1'b0;
            irq_service  <= 1'b0;
            exc_count_en <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    if (trap_return)
                    begin
                        // Unchanged mid frame resumes at the response read
                        cir_rd <= 1'b1; // see RQ3
                        state  <= ST_READ;
                    end
                    else if (instr_start)
                    begin
                        trace_pend <= (trace_mode_bits == `CPX_TRACE_ALL); // see RQ14
                        first_acc  <= 1'b1;
                        if (op_type[2:1] == 2'b11 || !op_valid)
                        begin
                            pend_vec <= `CPX_VEC_FLINE; // see RQ4
                            pend_frm <= `CPX_FRM_PRE4; // see RQ5
                            state    <= ST_EXC; // see RQ6
                        end
                        else if (cat_sr && !supervisor)
                        begin
                            pend_vec <= `CPX_VEC_PRIVILEGE; // see RQ10
                            pend_frm <= `CPX_FRM_PRE4;
                            state    <= ST_EXC;
                        end
                        else
                        begin
                            cir_rd <= 1'b1;
                            state  <= ST_READ;
                        end
                    end
                end
                ST_READ:
                begin
                    if (cir_done || cir_berr)
                    begin
                        cir_rd    <= 1'b0;
                        first_acc <= 1'b0;
                        prim      <= cir_rdata;
                        if (cir_berr && first_acc)
                        begin
                            pend_vec <= `CPX_VEC_FLINE; // see RQ8
                            pend_frm <= `CPX_FRM_PRE4; // see RQ9
                            state    <= ST_EXC;
                        end
                        else if (cir_berr)
                            state <= ST_IDLE;
                        else
                            state <= ST_EVAL;
                    end
                end
                ST_EVAL:
                begin
                    // Save/restore/conditional skip trace polling here
                    if (p_invalid)
                    begin
                        pend_vec <= `CPX_VEC_PROTOCOL; // see RQ22
                        pend_frm <= `CPX_FRM_MID10; // see RQ2
                        state    <= ST_EXC; // see RQ1
                    end
                    else if (p_supchk && !supervisor)
                    begin
                        pend_vec  <= `CPX_VEC_PRIVILEGE; // see RQ11
                        pend_frm  <= `CPX_FRM_PRE4; // see RQ12
                        cir_wr    <= 1'b1;
                        cir_wdata <= `CPX_ABORT_MASK;
                        state     <= ST_ABORT;
                    end
                    else if (p_ea && !ea_ctrl_alt)
                    begin
                        pend_vec  <= `CPX_VEC_FLINE; // see RQ7
                        pend_frm  <= `CPX_FRM_PRE4;
                        cir_wr    <= 1'b1;
                        cir_wdata <= `CPX_ABORT_MASK;
                        state     <= ST_ABORT;
                    end
                    else if (op_type == `CPX_TYPE_TRAPCC && p_null && !come_again_bit
                             && prim[`CPX_PRIM_TRUE_BIT])
                    begin
                        pend_vec  <= `CPX_VEC_TRAP; // see RQ13
                        pend_frm  <= `CPX_FRM_POST6;
                        pend_scan <= 1'b1;
                        state     <= ST_EXC;
                    end
                    else
                    begin
                        if (flow_hit)
                            trace_pend <= 1'b1; // see RQ20
                        if (come_again_bit)
                        begin
                            if (p_null && interrupts_allowed_bit && irq_pending)
                                state <= ST_IRQ;
                            else
                            begin
                                cir_rd <= 1'b1;
                                state  <= ST_READ;
                            end
                        end
                        else if (cat_gen && trace_pend && trace_mode_bits == `CPX_TRACE_ALL
                                 && !(p_null && processing_finished_bit))
                        begin
                            // Unfinished null keeps polling
                            if (p_null && interrupts_allowed_bit && irq_pending)
                                state <= ST_IRQ; // see RQ19
                            else
                            begin
                                cir_rd <= 1'b1; // see RQ17
                                state  <= ST_READ; // see RQ18
                            end
                        end
                        else if (trace_pend || flow_hit || (cat_cond && flow_change
                                 && trace_mode_bits == `CPX_TRACE_FLOW))
                        begin
                            pend_vec <= `CPX_VEC_TRACE; // see RQ15
                            pend_frm <= `CPX_FRM_POST6;
                            state    <= ST_EXC;
                        end
                        else
                        begin
                            instr_done <= 1'b1; // see RQ16
                            state      <= ST_IDLE;
                        end
                    end
                end
                ST_ABORT:
                begin
                    if (cir_done || cir_berr)
                    begin
                        cir_wr <= 1'b0; // see RQ24
                        state  <= ST_EXC;
                    end
                end
                ST_IRQ:
                begin
                    irq_service <= 1'b1;
                    cir_rd      <= 1'b1;
                    state       <= ST_READ;
                end
                ST_EXC:
                begin
                    exc_req       <= 1'b1;
                    exc_vector    <= pend_vec; // see RQ24
                    exc_frame     <= pend_frm;
                    exc_scan_next <= pend_scan;
                    if (exc_req && exc_ack)
                    begin
                        exc_req      <= 1'b0;
                        pend_scan    <= 1'b0;
                        trace_pend   <= 1'b0;
                        last_vec     <= pend_vec;
                        exc_count_en <= 1'b1;
                        state        <= ST_IDLE;
                    end
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
            exc_count <= 8'h00;
        else if (exc_count_en)
            exc_count <= exc_count + 8'h01;
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave: one write and one read outstanding

    reg        aw_held;
    reg        w_held;
    reg [3:0]  aw_addr;
    reg [31:0] w_data;
    reg [3:0]  w_strb;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    wire aw_ok = aw_held || s_axi_awvalid;
    wire w_ok  = w_held || s_axi_wvalid;
    wire [3:0] wa = aw_held ? aw_addr : s_axi_awaddr;
    wire [31:0] wd = w_held ? w_data : s_axi_wdata;
    wire [3:0] ws = w_held ? w_strb : s_axi_wstrb;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held         <= 1'b0;
            w_held          <= 1'b0;
            aw_addr         <= 4'h0;
            w_data          <= 32'h00000000;
            w_strb          <= 4'h0;
            s_axi_bvalid    <= 1'b0;
            s_axi_bresp     <= 2'h0;
            trace_mode_bits <= `CPX_CTRL_RESET;
        end
        else
        begin
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (aw_ok && w_ok && !s_axi_bvalid)
            begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (wa == `CPX_ADDR_CTRL)
                begin
                    s_axi_bresp <= 2'h0;
                    if (ws[0])
                        trace_mode_bits <= wd[1:0];
                end
                else if (wa == `CPX_ADDR_STATUS || wa == `CPX_ADDR_RESULT)
                    s_axi_bresp <= 2'h0;
                else
                    s_axi_bresp <= 2'h2;
            end
            else
            begin
                if (s_axi_awvalid && s_axi_awready)
                begin
                    aw_held <= 1'b1;
                    aw_addr <= s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready)
                begin
                    w_held <= 1'b1;
                    w_data <= s_axi_wdata;
                    w_strb <= s_axi_wstrb;
                end
            end
        end
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= 2'h0;
        end
        else if (s_axi_rvalid)
        begin
            if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
        else if (s_axi_arvalid)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'h0;
            case (s_axi_araddr)
                `CPX_ADDR_CTRL:   s_axi_rdata <= {30'h00000000, trace_mode_bits};
                `CPX_ADDR_STATUS: s_axi_rdata <= {22'h000000, trace_pend, state, |exc_count,
                                                  exc_frame, exc_req, 2'h0};
                `CPX_ADDR_RESULT: s_axi_rdata <= {8'h00, exc_count, last_vec, 8'h00};
                default:
                begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end
    end

endmodule

/* File: verilog/cpx_prim_decode.v */
`timescale 1ns/10ps
`include "cpx_defines.vh"

module cpx_prim_decode
(
    input  wire [15:0] prim,
    input  wire        cond_cat,
    output reg         invalid,
    output reg         is_null,
    output reg         is_supchk,
    output reg         is_status,
    output reg         ea_op
);

    reg [5:0] fn;

    always @*
    begin
        fn        = prim[`CPX_PRIM_FN_HI:`CPX_PRIM_FN_LO];
        invalid   = 1'b0;
        is_null   = 1'b0;
        is_supchk = 1'b0;
        is_status = 1'b0;
        ea_op     = 1'b0;
        // Reserved codes stay violations so a handler can emulate them
        if (fn == 6'h00 || fn == 6'h3F)
            invalid = 1'b1; // see RQ23
        else if (fn == 6'h0B || fn == 6'h1F || (fn >= 6'h18 && fn <= 6'h1B) ||
                 (fn >= 6'h28 && fn <= 6'h2B) || (fn >= 6'h38 && fn <= 6'h3B))
            invalid = 1'b1; // see RQ22
        else
        begin
            is_null   = (fn[4:0] == 5'h02) || (fn[4:0] == 5'h12);
            is_supchk = (fn == `CPX_PRIM_SUPCHK);
            is_status = (fn[4:0] == 5'h03);
            ea_op     = (fn[5:2] == 4'h2) || (fn[5:2] == 4'h3);
            if (cond_cat && !prim[`CPX_PRIM_CA] && !is_null)
                invalid = 1'b1; // see RQ21
            if (cond_cat && (is_status || ea_op))
                invalid = 1'b1; // see RQ21
        end
    end

endmodule
